// ---- rtl/mpfs_consts.svh ----
// Offsets, fields, reset values and mode status bits of the mode pin select block.
`ifndef MPFS_CONSTS_SVH
`define MPFS_CONSTS_SVH

// Pin count and status width (one event per pin plus power event).
`define MPFS_PIN_COUNT 12
`define MPFS_STAT_W 13
`define MPFS_PME_BIT 12

// Word indices of the registers on the bus (byte address is four times).
`define MPFS_REG_LCC 6'h00
`define MPFS_REG_OUT 6'h01
`define MPFS_REG_DIR 6'h02
`define MPFS_REG_IN 6'h03
`define MPFS_REG_STAT 6'h04
`define MPFS_REG_MASK 6'h05
`define MPFS_REG_MODE 6'h06
`define MPFS_REG_EEP 6'h07
`define MPFS_REG_SUBSYS 6'h08

// Local configuration fields.
`define MPFS_LCC_P1_LO 5
`define MPFS_LCC_P1_HI 6
`define MPFS_LCC_PME 7
`define MPFS_LCC_RESET 8'h00

// EEPROM control bits.
`define MPFS_EEP_CLK 0
`define MPFS_EEP_CS 1
`define MPFS_EEP_DO 2
`define MPFS_EEP_DI 3

// Mode status bits.
`define MPFS_MST_MINI 3
`define MPFS_MST_RSVD 4

// Standalone address split.
`define MPFS_HA_UART_HI 4
`define MPFS_HA_UART_LO 3
`define MPFS_HA_REG_HI 2

`endif

// ---- rtl/mpfs_mode_pin_select.sv ----
// Mode strap decode, multi-purpose pin roles, EEPROM pins and registers.
//
// Implementation choices: the register offsets and the Wishbone slave port.
`timescale 1ns/10ps
`include "mpfs_consts.svh"
module mpfs_mode_pin_select
    import mpfs_pkg::*;
#(
    // Subsystem IDs outside mode 010; values are arbitrary.
    parameter logic [15:0] DefaultSubId = 16'h0000,
    parameter logic [15:0] DefaultSubVendorId = 16'h0000
) (
    // Clock and reset.
    input wire logic clock,
    input wire logic reset,
    // Wishbone slave.
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // Straps.
    input wire logic [2:0] modeStraps,
    input wire logic [15:0] subsystemIdStraps,
    input wire logic [15:0] subsystemVendorIdStraps,
    // Multi-purpose pins, bit n is pin n.
    input wire logic [11:0] multiPurposePinsIn,
    output logic [11:0] multiPurposePinsOut,
    output logic [11:0] multiPurposePinsOe,
    // Serial EEPROM.
    output logic eepromSerialClock,
    output logic eepromChipSelect,
    output logic eepromSerialOutput,
    input wire logic eepromSerialInput,
    // Standalone host address.
    input wire logic [4:0] hostAddress,
    output logic [3:0] uartSelect,
    output logic [2:0] uartRegister,
    // Function configuration.
    output logic func1LocalBus,
    output logic func1ParallelPort,
    output logic func1Unusable,
    output logic uartsUniqueBars,
    output logic enhancedMode,
    output logic modeReserved,
    output logic busTypeMiniPci,
    output logic powerEventRequest,
    output logic [15:0] subsystemId,
    output logic [15:0] subsystemVendorId,
    // Interrupt.
    output logic irq
);
    localparam int PinCount = `MPFS_PIN_COUNT;

    // Register state.
    mpfs_mode_e mode_ff; // Mode captured while reset is held.
    logic [7:0] lcc_ff; // Local configuration control.
    logic [11:0] gpioOut_ff; // Output values.
    logic [11:0] gpioDir_ff; // Output enables, one means drive.
    logic [12:0] status_ff; // Sticky events.
    logic [12:0] mask_ff; // Interrupt enables.
    logic [2:0] eep_ff; // EEPROM clock, select and data.
    logic [15:0] subId_ff;
    logic [15:0] subVid_ff;
    logic miniPci_ff; // Sampled bus type.
    logic [3:0] uartSel_ff;
    logic [2:0] uartReg_ff;
    logic [4:0] func_ff; // Registered function decode.
    logic ack_ff;
    logic [31:0] datO_ff;

    // Mode groups.
    wire modeGroupA = (mode_ff == MODE_UART_LB) ||
        (mode_ff == MODE_ENH_BARS) || (mode_ff == MODE_ENH_LB);
    wire modeNoPin0 = (mode_ff == MODE_UART_PP) ||
        (mode_ff == MODE_ENH_PP) || (mode_ff == MODE_UART_SID);
    wire modeEnh = (mode_ff == MODE_ENH_BARS) ||
        (mode_ff == MODE_ENH_LB) || (mode_ff == MODE_ENH_PP);
    wire modeEarly = (mode_ff == MODE_UART_LB) ||
        (mode_ff == MODE_UART_PP) || (mode_ff == MODE_UART_SID);
    wire modeStandalone = (mode_ff == MODE_STANDALONE);
    wire modeRsvd = (mode_ff == MODE_RESERVED);
    wire modeActive = !modeStandalone && !modeRsvd;
    wire [1:0] pin1Field = lcc_ff[`MPFS_LCC_P1_HI:`MPFS_LCC_P1_LO];
    wire pmeSelect = lcc_ff[`MPFS_LCC_PME];

    // Pin roles. Standalone and reserved modes leave pins undriven; in
    // standalone the board holds them low, so nothing is lost.
    mpfs_role_e pinRole [PinCount];
    assign pinRole[0] = modeGroupA ? ROLE_GPIO :
        (modeNoPin0 ? ROLE_LOW : ROLE_OFF);
    assign pinRole[1] = !modeActive ? ROLE_OFF :
        ((pin1Field == 2'b00) ? ROLE_GPIO : ROLE_LOW);
    assign pinRole[2] = (!modeActive || mode_ff == MODE_UART_SID) ?
        ROLE_OFF : (pmeSelect ? ROLE_ALT : ROLE_GPIO);
    assign pinRole[11] = modeEarly ? ROLE_GPIO :
        (modeEnh ? ROLE_ALT : ROLE_OFF);

    // Per-pin event lines.
    wire [11:0] gpioEvent;
    wire [11:0] altEvent;

    // One cell per pin; pins three to ten share one role.
    genvar gi;
    generate
        for (gi = 0; gi < PinCount; gi = gi + 1) begin : g_pin
            if (gi >= 3 && gi <= 10) begin : g_upper
                assign pinRole[gi] = modeGroupA ? ROLE_GPIO : ROLE_OFF;
            end
            mpfs_pin_cell u_cell (
                .clock(clock),
                .reset(reset),
                .role(pinRole[gi]),
                .outValue(gpioOut_ff[gi]),
                .outEnable(gpioDir_ff[gi]),
                .pinIn(multiPurposePinsIn[gi]),
                .pinOut(multiPurposePinsOut[gi]),
                .pinOe(multiPurposePinsOe[gi]),
                .gpioEvent(gpioEvent[gi]),
                .altEvent(altEvent[gi])
            );
        end
    endgenerate

    // Bus decode.
    wire access = cyc_i && stb_i && !ack_ff;
    wire [5:0] wordIdx = adr_i[7:2];
    wire wrEn = access && we_i;
    wire [31:0] byteMask = {{8{sel_i[3]}}, {8{sel_i[2]}},
        {8{sel_i[1]}}, {8{sel_i[0]}}};
    wire [31:0] wrBits = dat_i & byteMask;
    wire hitLcc = wordIdx == `MPFS_REG_LCC;
    wire hitOut = wordIdx == `MPFS_REG_OUT;
    wire hitDir = wordIdx == `MPFS_REG_DIR;
    wire hitStat = wordIdx == `MPFS_REG_STAT;
    wire hitMask = wordIdx == `MPFS_REG_MASK;
    wire hitEep = wordIdx == `MPFS_REG_EEP;

    // Merge helper for byte-lane writes.
    wire [31:0] lccMerged = ({24'h000000, lcc_ff} & ~byteMask) | wrBits;
    wire [31:0] outMerged = ({20'h00000, gpioOut_ff} & ~byteMask) | wrBits;
    wire [31:0] dirMerged = ({20'h00000, gpioDir_ff} & ~byteMask) | wrBits;
    wire [31:0] maskMerged = ({19'h00000, mask_ff} & ~byteMask) | wrBits;
    wire [31:0] eepMerged = ({29'h00000000, eep_ff} & ~byteMask) | wrBits;

    // Events: pin edges plus the power event from pin two.
    wire [12:0] events = {altEvent[2], gpioEvent};
    wire [12:0] clearBits = (wrEn && hitStat) ? wrBits[12:0] : 13'h0000;

    // Mode status word.
    wire [31:0] modeWord = {24'h000000, func_ff, 3'h0} |
        {27'h0000000, modeRsvd, miniPci_ff, mode_ff};

    // Read selection; unmapped words read as zero.
    logic [31:0] rdData;
    always_comb begin
        case (wordIdx)
            `MPFS_REG_LCC: rdData = {24'h000000, lcc_ff};
            `MPFS_REG_OUT: rdData = {20'h00000, gpioOut_ff};
            `MPFS_REG_DIR: rdData = {20'h00000, gpioDir_ff};
            `MPFS_REG_IN: rdData = {20'h00000, multiPurposePinsIn};
            `MPFS_REG_STAT: rdData = {19'h00000, status_ff};
            `MPFS_REG_MASK: rdData = {19'h00000, mask_ff};
            `MPFS_REG_MODE: rdData = modeWord;
            `MPFS_REG_EEP: rdData = {28'h0000000, eepromSerialInput,
                eep_ff};
            `MPFS_REG_SUBSYS: rdData = {subVid_ff, subId_ff};
            default: rdData = 32'h00000000;
        endcase
    end

    // Function decode from the mode.
    wire [4:0] nxt_func = {
        (mode_ff == MODE_UART_LB) || (mode_ff == MODE_ENH_BARS) ||
            (mode_ff == MODE_ENH_LB),
        (mode_ff == MODE_UART_PP) || (mode_ff == MODE_ENH_PP),
        (mode_ff == MODE_UART_SID),
        (mode_ff == MODE_ENH_BARS),
        modeEnh
    };

    // Standalone address split into UART and register.
    wire [1:0] haUart = hostAddress[`MPFS_HA_UART_HI:`MPFS_HA_UART_LO];
    wire [3:0] nxt_uartSel = modeStandalone ?
        (4'h1 << haUart) : 4'h0;
    wire [2:0] nxt_uartReg = modeStandalone ?
        hostAddress[`MPFS_HA_REG_HI:0] : 3'h0;

    // Straps are caught while reset is held and then stay fixed, so a
    // strap moving later has no effect; mode 110 is flagged, not used.
    always_ff @(posedge clock) begin
        if (reset) begin
            mode_ff <= mpfs_mode_e'(modeStraps);
        end
    end

    // Subsystem IDs: straps in mode 010, otherwise the defaults.
    always_ff @(posedge clock) begin
        if (reset) begin
            if (modeStraps == MODE_UART_SID) begin
                subId_ff <= subsystemIdStraps;
                subVid_ff <= subsystemVendorIdStraps;
            end else begin
                subId_ff <= DefaultSubId;
                subVid_ff <= DefaultSubVendorId;
            end
        end
    end

    // Configuration registers.
    always_ff @(posedge clock) begin
        if (reset) begin
            lcc_ff <= `MPFS_LCC_RESET;
            gpioOut_ff <= 12'h000;
            gpioDir_ff <= 12'h000;
            mask_ff <= 13'h0000;
            eep_ff <= 3'h0;
        end else if (wrEn) begin
            if (hitLcc) lcc_ff <= lccMerged[7:0];
            if (hitOut) gpioOut_ff <= outMerged[11:0];
            if (hitDir) gpioDir_ff <= dirMerged[11:0];
            if (hitMask) mask_ff <= maskMerged[12:0];
            if (hitEep) eep_ff <= eepMerged[2:0];
        end
    end

    // Sticky status: an event in the clearing cycle survives.
    always_ff @(posedge clock) begin
        if (reset) begin
            status_ff <= 13'h0000;
        end else begin
            status_ff <= (status_ff & ~clearBits) | events;
        end
    end

    // Bus type follows pin eleven in enhanced modes, PCI otherwise.
    always_ff @(posedge clock) begin
        if (reset) begin
            miniPci_ff <= 1'b0;
        end else begin
            miniPci_ff <= modeEnh && multiPurposePinsIn[11];
        end
    end

    // Decoded outputs, registered.
    always_ff @(posedge clock) begin
        if (reset) begin
            func_ff <= 5'h00;
            uartSel_ff <= 4'h0;
            uartReg_ff <= 3'h0;
        end else begin
            func_ff <= nxt_func;
            uartSel_ff <= nxt_uartSel;
            uartReg_ff <= nxt_uartReg;
        end
    end

    // Single-cycle acknowledge; the flag blocks a second answer.
    always_ff @(posedge clock) begin
        if (reset) begin
            ack_ff <= 1'b0;
            datO_ff <= 32'h00000000;
        end else begin
            ack_ff <= access;
            if (access && !we_i) datO_ff <= rdData;
        end
    end

    // Output wiring.
    assign ack_o = ack_ff;
    assign dat_o = datO_ff;
    assign eepromSerialClock = eep_ff[`MPFS_EEP_CLK];
    assign eepromChipSelect = eep_ff[`MPFS_EEP_CS];
    assign eepromSerialOutput = eep_ff[`MPFS_EEP_DO];
    assign uartSelect = uartSel_ff;
    assign uartRegister = uartReg_ff;
    assign func1LocalBus = func_ff[4];
    assign func1ParallelPort = func_ff[3];
    assign func1Unusable = func_ff[2];
    assign uartsUniqueBars = func_ff[1];
    assign enhancedMode = func_ff[0];
    assign modeReserved = modeRsvd;
    assign busTypeMiniPci = miniPci_ff;
    assign powerEventRequest = status_ff[`MPFS_PME_BIT];
    assign subsystemId = subId_ff;
    assign subsystemVendorId = subVid_ff;
    assign irq = |(status_ff & mask_ff);

    // The edge that ends reset still samples reset high, while the flops
    // only leave their reset values one edge later. Checks whose consequent
    // would fail on those reset values name reset in the antecedent.

    // Pin zero as driven I/O in the group A modes.
    chk_pin0_gpio_drive: assert property (
        @(posedge clock) disable iff (reset)
        modeGroupA && gpioDir_ff[0] |=> multiPurposePinsOe[0] &&
        multiPurposePinsOut[0] == $past(gpioOut_ff[0]))
        else $error("pin zero does not follow its output register");

    // Pin zero driven low in the other function modes.
    chk_pin0_low: assert property (
        @(posedge clock) disable iff (reset)
        !reset && modeNoPin0 |=> multiPurposePinsOe[0] &&
        !multiPurposePinsOut[0])
        else $error("pin zero not driven low");

    // Pin one driven low while its field is not zero.
    chk_pin1_field: assert property (
        @(posedge clock) disable iff (reset)
        modeActive && pin1Field != 2'b00 ##1 $stable(lcc_ff)
        |-> multiPurposePinsOe[1] && !multiPurposePinsOut[1])
        else $error("pin one not held low");

    // Pin two as I/O while the power-event bit is clear.
    chk_pin2_gpio: assert property (
        @(posedge clock) disable iff (reset)
        modeActive && mode_ff != MODE_UART_SID && !pmeSelect &&
        gpioDir_ff[2] |=> multiPurposePinsOe[2])
        else $error("pin two not driving as I/O");

    // Pin two rising edge raises the power event next cycle.
    chk_pme_event: assert property (
        @(posedge clock) disable iff (reset)
        altEvent[2] |=> powerEventRequest [*2])
        else $error("power event not raised and held");

    // Upper pins listen outside the group A modes.
    chk_upper_off: assert property (
        @(posedge clock) disable iff (reset)
        !modeGroupA |=> multiPurposePinsOe[10:3] == 8'h00)
        else $error("upper pins driven outside their modes");

    // Pin eleven never driven in enhanced modes.
    chk_pin11_input: assert property (
        @(posedge clock) disable iff (reset)
        modeEnh |=> !multiPurposePinsOe[11])
        else $error("bus select pin driven");

    // Bus type follows the select pin.
    chk_bus_type: assert property (
        @(posedge clock) disable iff (reset)
        !reset && modeEnh |=>
        busTypeMiniPci == $past(multiPurposePinsIn[11]))
        else $error("bus type does not follow select pin");

    // EEPROM select follows a write to its register.
    chk_eeprom_write: assert property (
        @(posedge clock) disable iff (reset)
        wrEn && hitEep && sel_i[0] |=>
        eepromChipSelect == $past(dat_i[`MPFS_EEP_CS]))
        else $error("EEPROM select not written");

    // Standalone UART select matches the address one cycle on.
    chk_uart_select: assert property (
        @(posedge clock) disable iff (reset)
        !reset && modeStandalone |=>
        uartSelect == (4'h1 << $past(haUart)))
        else $error("standalone UART select wrong");

    // Mode never changes outside reset.
    chk_mode_static: assert property (
        @(posedge clock) disable iff (reset)
        1'b1 |=> $stable(mode_ff))
        else $error("mode changed after reset");

    // Function decode for the enhanced parallel port mode.
    chk_func_decode: assert property (
        @(posedge clock) disable iff (reset)
        !reset && mode_ff == MODE_ENH_PP |=> func1ParallelPort &&
        enhancedMode && !func1LocalBus)
        else $error("function decode wrong in mode 101");
endmodule : mpfs_mode_pin_select

// ---- rtl/mpfs_pin_cell.sv ----
// One multi-purpose pin: role driven output stage and edge detection.
`timescale 1ns/10ps
module mpfs_pin_cell
    import mpfs_pkg::*;
(
    // Clock and reset.
    input wire logic clock,
    input wire logic reset,
    // Control from the register file.
    input wire mpfs_role_e role,
    input wire logic outValue,
    input wire logic outEnable,
    // Pin signals.
    input wire logic pinIn,
    output logic pinOut,
    output logic pinOe,
    // Events towards the status register.
    output logic gpioEvent,
    output logic altEvent
);
    logic prev_ff; // Last sampled pin level.
    logic nxt_pinOut;
    logic nxt_pinOe;

    // Output stage: low role forces a driven zero, alternate roles listen.
    always_comb begin
        nxt_pinOut = 1'b0;
        nxt_pinOe = 1'b0;
        case (role)
            ROLE_GPIO: begin
                nxt_pinOut = outValue;
                nxt_pinOe = outEnable;
            end
            ROLE_LOW: begin
                nxt_pinOe = 1'b1;
            end
            default: begin
                nxt_pinOe = 1'b0;
            end
        endcase
    end

    // Registered pin drive, so the pads never see decode glitches.
    // The edge detector tracks the pin even in reset. A pin held high
    // through reset would otherwise look like a rising edge on release.
    always_ff @(posedge clock) begin
        if (reset) begin
            pinOut <= 1'b0;
            pinOe <= 1'b0;
            prev_ff <= pinIn;
        end else begin
            pinOut <= nxt_pinOut;
            pinOe <= nxt_pinOe;
            prev_ff <= pinIn;
        end
    end

    // Rising edge while listening: an input I/O or an alternate input.
    assign gpioEvent = (role == ROLE_GPIO) && !outEnable && pinIn && !prev_ff;
    assign altEvent = (role == ROLE_ALT) && pinIn && !prev_ff;
endmodule : mpfs_pin_cell

// ---- rtl/mpfs_pkg.sv ----
// Types shared by the mode pin select block.
package mpfs_pkg;
    // Role of one multi-purpose pin.
    typedef enum logic [1:0] {
        ROLE_GPIO = 2'b00,
        ROLE_LOW = 2'b01,
        ROLE_ALT = 2'b10,
        ROLE_OFF = 2'b11
    } mpfs_role_e;

    // Mode strap codes.
    typedef enum logic [2:0] {
        MODE_UART_LB = 3'b000,
        MODE_UART_PP = 3'b001,
        MODE_UART_SID = 3'b010,
        MODE_ENH_BARS = 3'b011,
        MODE_ENH_LB = 3'b100,
        MODE_ENH_PP = 3'b101,
        MODE_RESERVED = 3'b110,
        MODE_STANDALONE = 3'b111
    } mpfs_mode_e;
endpackage : mpfs_pkg

// ---- testbench/mpfs_board_model.sv ----
// Board model: event pin levels, bus type strap and a serial EEPROM.
`timescale 1ns/10ps
module mpfs_board_model (
    // Levels the board puts on pins that nobody drives.
    input wire logic [11:0] boardLevel,
    input wire logic standalone,
    // Device pin drive.
    input wire logic [11:0] pinsOut,
    input wire logic [11:0] pinsOe,
    // EEPROM wires from the device.
    input wire logic eepCs,
    input wire logic eepDo,
    // Levels seen by the device.
    output logic [11:0] pinsIn,
    output logic eepDi
);
    // A standalone board ties every pin low.
    wire logic [11:0] tieLevel = standalone ? 12'h000 : boardLevel;
    // A driven pin shows the device value, otherwise the board level.
    assign pinsIn = (pinsOe & pinsOut) | (~pinsOe & tieLevel);
    // A selected EEPROM echoes its data; deselected, the pull-up wins.
    assign eepDi = eepCs ? eepDo : 1'b1;
endmodule : mpfs_board_model

// ---- testbench/tb.sv ----
// Self-checking bench of the mode pin select block.
`timescale 1ns/10ps
module tb
    import mpfs_pkg::*;
;
    // Bus, strap and pin stimulus.
    logic clock = 1'b0;
    logic reset = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rd;
    logic [31:0] rnd;
    logic [2:0] mode = 3'h0;
    logic [15:0] sid = 16'h0;
    logic [15:0] svid = 16'h0;
    logic [11:0] level = 12'h000;
    logic [4:0] hAdr = 5'h00;
    // Design outputs.
    logic [11:0] pIn, pOut, pOe;
    logic eClk, eCs, eDo, eDi, ack;
    logic [3:0] uSel;
    logic [2:0] uReg;
    logic lb, pp, un, ub, en, rsv, mini, pme, irq;
    logic [31:0] rdat;
    logic [15:0] sidO, svidO;
    int errTotal = 0;
    int totalChecks = 0;
    int seed = 32'h9dad8b7f;
    // EEPROM control patterns, first one in the top three bits.
    logic [11:0] eepSeq = {3'h7, 3'h2, 3'h0, 3'h5};

    always #5 clock = ~clock;

    mpfs_mode_pin_select uut (.clock(clock), .reset(reset), .cyc_i(cyc),
        .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(4'hf), .dat_i(wdat),
        .dat_o(rdat), .ack_o(ack), .modeStraps(mode),
        .subsystemIdStraps(sid), .subsystemVendorIdStraps(svid),
        .multiPurposePinsIn(pIn), .multiPurposePinsOut(pOut),
        .multiPurposePinsOe(pOe), .eepromSerialClock(eClk),
        .eepromChipSelect(eCs), .eepromSerialOutput(eDo),
        .eepromSerialInput(eDi), .hostAddress(hAdr), .uartSelect(uSel),
        .uartRegister(uReg), .func1LocalBus(lb), .func1ParallelPort(pp),
        .func1Unusable(un), .uartsUniqueBars(ub), .enhancedMode(en),
        .modeReserved(rsv), .busTypeMiniPci(mini),
        .powerEventRequest(pme), .subsystemId(sidO),
        .subsystemVendorId(svidO), .irq(irq));

    mpfs_board_model board (.boardLevel(level),
        .standalone(mode == 3'b111), .pinsOut(pOut), .pinsOe(pOe),
        .eepCs(eCs), .eepDo(eDo), .pinsIn(pIn), .eepDi(eDi));

    // Prints the counts and the verdict, then ends the run.
    task report_and_stop();
        $display("checks %0d errors %0d", totalChecks, errTotal);
        if (errTotal == 0 && totalChecks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : report_and_stop

    // Compares one seen value with the model's value.
    task check(input logic [31:0] seen, input logic [31:0] exp);
        totalChecks++;
        if (seen !== exp) begin
            errTotal++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    // One classic cycle; the request holds until ack is sampled high.
    task automatic wb(input logic w, input logic [7:0] a,
            input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clock);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge clock);
            n++;
        end while (ack !== 1'b1 && n < 50);
        rd = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        // A slave that never answers ends the run as a failure.
        if (n >= 50) begin
            errTotal++;
            report_and_stop();
        end
    endtask : wb

    // Polls the status register; event capture latency is left open.
    task automatic wait_stat(input logic [31:0] e);
        int n;
        n = 0;
        do begin
            wb(1'b0, 8'h10, 32'h0);
            n++;
        end while (rd !== e && n < 20);
        check(rd, e);
        // A status that never settles ends the run as a failure.
        if (rd !== e) begin
            report_and_stop();
        end
    endtask : wait_stat

    // Resets with new straps; mode is held static afterwards.
    task do_reset(input int m);
        @(posedge clock);
        rnd = $random(seed);
        reset <= 1'b1;
        mode <= m[2:0];
        sid <= rnd[15:0];
        svid <= rnd[31:16];
        hAdr <= rnd[4:0];
        repeat (4) @(posedge clock);
        reset <= 1'b0;
        repeat (2) @(posedge clock);
    endtask : do_reset

    // Expected enables with every pin set as an output.
    function logic [11:0] eoe(int m, logic [7:0] local_config_control);
        logic g0, off;
        g0 = (m == 0 || m == 3 || m == 4);
        off = (m >= 6);
        eoe[0] = !off;
        eoe[1] = !off;
        eoe[2] = !(off || m == 2 || local_config_control[7]);
        eoe[10:3] = g0 ? 8'hff : 8'h00;
        eoe[11] = (m <= 2);
    endfunction : eoe

    // Expected drive: general I/O pins show the output register.
    function logic [11:0] eout(int m, logic [7:0] local_config_control, logic [11:0] o);
        logic [11:0] g;
        g = eoe(m, local_config_control);
        g[0] = (m == 0 || m == 3 || m == 4);
        g[1] = g[1] && (local_config_control[6:5] == 2'b00);
        eout = g & o;
    endfunction : eout

    // Expected function flags {bus, port, unusable, bars, enh, rsvd}.
    function logic [5:0] efunc(int m);
        efunc = {m == 0 || m == 3 || m == 4, m == 1 || m == 5, m == 2,
            m == 3, m >= 3 && m <= 5, m == 6};
    endfunction : efunc

    initial begin
        // Every mode code: pin roles, function flags and straps.
        for (int m = 0; m < 8; m++) begin
            do_reset(m);
            level <= {m[0], 11'h000};
            wb(1'b1, 8'h08, 32'hfff);
            wb(1'b1, 8'h04, rnd);
            repeat (2) @(posedge clock);
            check(pOe, eoe(m, 8'h00));
            check(pOut & pOe, eout(m, 8'h00, rnd[11:0]));
            check({lb, pp, un, ub, en, rsv}, efunc(m));
            check(mini, m >= 3 && m <= 5 && m[0]);
            check({uSel, uReg}, m == 7 ?
                {4'h1 << hAdr[4:3], hAdr[2:0]} : 7'h00);
            wb(1'b0, 8'h20, 32'h0);
            check(rd, m == 2 ? {svid, sid} : 32'h0);
            check({svidO, sidO}, m == 2 ? {svid, sid} : 32'h0);
            wb(1'b0, 8'h18, 32'h0);
            check(rd[2:0], m[2:0]);
        end
        // Pin one field: only 00 leaves it as general I/O.
        do_reset(0);
        wb(1'b1, 8'h08, 32'hfff);
        wb(1'b1, 8'h04, 32'hfff);
        for (int f = 0; f < 4; f++) begin
            wb(1'b1, 8'h00, f << 5);
            wb(1'b0, 8'h00, 32'h0);
            check(rd, f << 5);
            check({pOe[1], pOut[1]}, {1'b1, f == 0});
        end
        // Input events on pins zero, two and five, then w1c and mask.
        wb(1'b1, 8'h08, 32'h0);
        wb(1'b1, 8'h00, 32'h0);
        wb(1'b1, 8'h14, 32'h1fff);
        level <= 12'h025;
        wait_stat(32'h25);
        check(irq, 1'b1);
        wb(1'b1, 8'h10, 32'h25);
        wait_stat(32'h0);
        check(irq, 1'b0);
        wb(1'b1, 8'h14, 32'h0);
        level <= 12'h065;
        wait_stat(32'h40);
        check(irq, 1'b0);
        wb(1'b1, 8'h10, 32'h1fff);
        // Power-event select: pin two raises the power event bit, not its own status bit.
        wb(1'b1, 8'h00, 32'h80);
        wb(1'b1, 8'h14, 32'h1000);
        level <= 12'h061;
        repeat (2) @(posedge clock);
        level <= 12'h065;
        wait_stat(32'h1000);
        check({pme, irq}, 2'b11);
        // EEPROM wires and the pulled-up data input.
        for (int i = 3; i >= 0; i--) begin
            rnd = {29'h0, eepSeq[i * 3 +: 3]};
            wb(1'b1, 8'h1c, rnd);
            wb(1'b0, 8'h1c, 32'h0);
            check({eDo, eCs, eClk}, rnd[2:0]);
            check(rd[3:0], {rnd[1] ? rnd[2] : 1'b1, rnd[2:0]});
        end
        // Unmapped word: acked, reads zero, write ignored.
        wb(1'b1, 8'h3c, 32'hffffffff);
        wb(1'b0, 8'h3c, 32'h0);
        check(rd, 32'h0);
        report_and_stop();
    end
endmodule : tb
